// ===== core/cal_ctl_pkg.sv
// package: register map, field positions and types of the calendar control
package cal_ctl_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL_A   = 12'h000;
  localparam logic [11:0] ADDR_ALARM    = 12'h004;
  localparam logic [11:0] ADDR_DIV_LO   = 12'h008;
  localparam logic [11:0] ADDR_DIV_HI   = 12'h00c;
  localparam logic [11:0] ADDR_KEY      = 12'h010;
  localparam logic [11:0] ADDR_STATUS   = 12'h014;
  localparam logic [11:0] ADDR_TIME     = 12'h018;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RUN_BIT   = 15;
  localparam int GUARD_BIT = 11;
  localparam int PWEN_BIT  = 10;
  localparam int PWPOL_BIT = 9;
  localparam int PWOE_BIT  = 8;
  localparam int TOE_BIT   = 7;
  localparam int ARM_BIT   = 15;
  localparam int ENDL_BIT  = 14;

  // ----------------------------------------------------------------
  // key bytes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  KEY_FIRST     = 8'h55;
  localparam logic [7:0]  KEY_SECOND    = 8'haa;
  localparam logic [15:0] DIV_HI_RESET  = 16'hffff;
  localparam logic [15:0] CTRL_A_MASK   = 16'h8ff1;
  localparam logic [15:0] ALARM_MASK    = 16'hcfff;
  localparam logic [15:0] DIV_LO_MASK   = 16'hf8f3;
  localparam int          FRAC_SLOTS    = 32;

  // key sequence states
  typedef enum logic [1:0] {KEY_IDLE, KEY_ONE, KEY_OPEN} key_state_t;

  // all state of the block except the pin synchronisers and ref_prev_r
  typedef struct packed {
    logic [15:0] ctrl_a;
    logic [15:0] alarm;
    logic [15:0] div_lo;
    logic [15:0] div_hi;
    key_state_t  key;
    logic [7:0]  pre_cnt;
    logic [15:0] coarse_cnt;
    logic [4:0]  slot;
    logic        half;
    logic        sec_clk;
    logic [7:0]  pw_cnt;
    logic        pw_tick;
    logic [16:0] halves;
    logic        alarm_evt;
    logic        stamp_evt;
    logic [1:0]  tamp_hist;
    logic [31:0] prdata;
    logic        tick_out;
  } state_t;

endpackage

// ===== core/cal_ctl.sv
// calendar clock control: divider, write guard, alarm repeat, output mux
//
// Overview of operation
// - guard set: writes to run bit, divider registers and time ignored
// - alarm, power control and timestamp fields writable regardless of guard
// - guard is zero after any reset
// - guard clears only after key bytes 55h then AA back to back
// - clear must come in the very next write after the second key
// - guard clear: setting it needs no key
// - reference pick: 00 osc, 01 rc, 10 mains pin, 11 system clock
// - calendar counts only while run bit is set
// - output = input / (2 * prescale * (coarse+1)) plus fine term
// - fine value n adds n input cycles per 16 seconds, only with system clock reference and prescale 1; zero disables
// - power timing clock prescaled 1, 16, 64 or 256
// - power enable, polarity and pin drive control the power output
// - output pin shows source picked by select code when enabled
// - tamper low pulse raises timestamp event when stamping enabled
// - alarm arm clears after event when count zero and not endless
// - repeat count decrements per event; wraps only when endless
// - repeat count is eight bits, up to 255 further alarms
// - interval codes half second to year; codes 1010-1111 reserved
// - registers directly mapped, no register pointer
// - coarse divider is a 16-bit counter set by coarse value
// - fine circuit swallows one input pulse in each half second slot picked by the fine value
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/100ps

module cal_ctl
  import cal_ctl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        secondary_osc,
  input  wire logic        low_power_rc,
  input  wire logic        mains_clk_pin,
  input  wire logic        tamper_n_pin,
  input  wire logic        alarm_match,
  output logic             half_tick,
  output logic             pw_clk_tick,
  output logic             power_out,
  output logic             power_oe_n,
  output logic             tick_out,
  output logic             tick_oe_n
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;

  // two flops before any logic looks at an outside pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // tamper pin idles high: both stages start there, no false edge
      pin_s1_r <= 4'h8;
      pin_s2_r <= 4'h8;
    end else begin
      pin_s1_r <= {tamper_n_pin, mains_clk_pin, low_power_rc,
                   secondary_osc};
      pin_s2_r <= pin_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  state_t s_r;
  state_t s_nxt;
  logic   ref_prev_r;
  logic   ref_lvl;
  logic   ref_edge;
  logic   pre_tick;
  logic   wr;
  logic   rd;
  logic   fine_skip;
  logic   run;
  logic   guard;
  logic   arm_evt;

  // prescale ratio minus one for a 2-bit code
  function automatic logic [7:0] pre_last(input logic [1:0] code);
    case (code)
      2'b00:   pre_last = 8'h00;
      2'b01:   pre_last = 8'h0f;
      2'b10:   pre_last = 8'h3f;
      default: pre_last = 8'hff;
    endcase
  endfunction

  // bit-reversed slot compare spreads swallowed pulses over 16 s
  function automatic logic slot_hit(input logic [4:0] slot,
                                    input logic [4:0] trim);
    slot_hit = ({slot[0], slot[1], slot[2], slot[3], slot[4]} < trim);
  endfunction

  // reference selection; system clock is pclk itself, every edge counts
  always_comb begin
    case (s_r.div_lo[1:0])
      2'b00:   ref_lvl = pin_s2_r[0];
      2'b01:   ref_lvl = pin_s2_r[1];
      2'b10:   ref_lvl = pin_s2_r[2];
      default: ref_lvl = 1'b0;
    endcase
    ref_edge = (s_r.div_lo[1:0] == 2'b11) ? 1'b1
             : (ref_lvl & ~ref_prev_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev_r <= 1'b0;
    end else begin
      ref_prev_r <= ref_lvl;
    end
  end

  // apb decode: no wait states, unmapped reads zero, error only above the time register
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (paddr > ADDR_TIME);
  assign run     = s_r.ctrl_a[RUN_BIT];
  assign guard   = s_r.ctrl_a[GUARD_BIT];
  assign pre_tick  = ref_edge && (s_r.pre_cnt == pre_last(s_r.div_lo[5:4]));
  assign fine_skip = s_r.half && slot_hit(s_r.slot, s_r.div_lo[15:11]);
  assign arm_evt   = alarm_match & s_r.alarm[ARM_BIT];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt           = s_r;
    s_nxt.half      = 1'b0;
    s_nxt.pw_tick   = 1'b0;
    s_nxt.alarm_evt = 1'b0;
    s_nxt.stamp_evt = 1'b0;
    s_nxt.tamp_hist = {s_r.tamp_hist[0], pin_s2_r[3]};

    // synchronous prescaler and coarse divider on sampled reference edges, gated by run
    if (run && ref_edge) begin
      s_nxt.pre_cnt = pre_tick ? 8'h00 : s_r.pre_cnt + 8'h01;
    end
    if (!run) begin
      s_nxt.pre_cnt    = 8'h00;
      s_nxt.coarse_cnt = 16'h0000;
    end else if (pre_tick && !fine_skip) begin
      if (s_r.coarse_cnt == s_r.div_hi) begin
        s_nxt.coarse_cnt = 16'h0000;
        s_nxt.half       = 1'b1;
        s_nxt.slot       = s_r.slot + 5'd1;
        s_nxt.sec_clk    = ~s_r.sec_clk;
        s_nxt.halves     = s_r.halves + 17'd1;
      end else begin
        s_nxt.coarse_cnt = s_r.coarse_cnt + 16'h0001;
      end
    end

    // power control clock prescale runs on the reference
    if (ref_edge) begin
      if (s_r.pw_cnt == pre_last(s_r.div_lo[7:6])) begin
        s_nxt.pw_cnt  = 8'h00;
        s_nxt.pw_tick = s_r.ctrl_a[PWEN_BIT];
      end else begin
        s_nxt.pw_cnt = s_r.pw_cnt + 8'h01;
      end
    end

    // tamper falling edge makes a timestamp event
    if (s_r.ctrl_a[0] && s_r.tamp_hist == 2'b10) begin
      s_nxt.stamp_evt = 1'b1;
    end

    // alarm repeat counter and auto disarm
    if (arm_evt) begin
      s_nxt.alarm_evt = 1'b1;
      if (s_r.alarm[7:0] != 8'h00 || s_r.alarm[ENDL_BIT]) begin
        s_nxt.alarm[7:0] = s_r.alarm[7:0] - 8'h01;
      end else begin
        s_nxt.alarm[ARM_BIT] = 1'b0;
      end
    end

    // key sequence: any other write drops it
    if (wr) begin
      s_nxt.key = KEY_IDLE;
      if (paddr == ADDR_KEY && pwdata[7:0] == KEY_FIRST) begin
        s_nxt.key = KEY_ONE;
      end else if (paddr == ADDR_KEY && s_r.key == KEY_ONE
                   && pwdata[7:0] == KEY_SECOND) begin
        s_nxt.key = KEY_OPEN;
      end
    end

    // register writes
    if (wr) begin
      case (paddr)
        ADDR_CTRL_A: begin
          // free fields always writable
          s_nxt.ctrl_a[10:0] = pwdata[10:0] & CTRL_A_MASK[10:0];
          if (!guard) begin
            s_nxt.ctrl_a[RUN_BIT] = pwdata[RUN_BIT];
            s_nxt.ctrl_a[GUARD_BIT] = pwdata[GUARD_BIT];
          end else if (!pwdata[GUARD_BIT] && s_r.key == KEY_OPEN) begin
            s_nxt.ctrl_a[GUARD_BIT] = 1'b0;
          end
        end
        ADDR_ALARM: begin
          s_nxt.alarm = pwdata[15:0] & ALARM_MASK;
        end
        ADDR_DIV_LO: begin
          // power prescale is a power-control field, never locked
          s_nxt.div_lo[7:6] = pwdata[7:6];
          if (!guard) begin
            s_nxt.div_lo = pwdata[15:0] & DIV_LO_MASK;
          end
        end
        ADDR_DIV_HI: begin
          if (!guard) begin
            s_nxt.div_hi = pwdata[15:0];
          end
        end
        ADDR_TIME: begin
          if (!guard) begin
            s_nxt.halves = pwdata[16:0];
          end
        end
        default: begin
        end
      endcase
    end

    // read mux, each register its own word
    if (rd) begin
      case (paddr)
        ADDR_CTRL_A: s_nxt.prdata = {16'h0000, s_r.ctrl_a};
        ADDR_ALARM:  s_nxt.prdata = {16'h0000, s_r.alarm};
        ADDR_DIV_LO: s_nxt.prdata = {16'h0000, s_r.div_lo};
        ADDR_DIV_HI: s_nxt.prdata = {16'h0000, s_r.div_hi};
        ADDR_STATUS: s_nxt.prdata = {26'h0, s_r.alarm_evt, 1'b0,
                                     s_r.stamp_evt, 2'b00, s_r.sec_clk};
        ADDR_TIME:   s_nxt.prdata = {15'h0000, s_r.halves};
        default:     s_nxt.prdata = 32'h0000_0000;
      endcase
    end

    // output pin source
    case (s_r.ctrl_a[6:4])
      3'b000:  s_nxt.tick_out = s_r.alarm_evt;
      3'b001:  s_nxt.tick_out = s_r.sec_clk;
      3'b010:  s_nxt.tick_out = ref_lvl;
      3'b011:  s_nxt.tick_out = s_r.pw_tick;
      3'b100:  s_nxt.tick_out = s_r.stamp_evt;
      default: s_nxt.tick_out = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // state register; reset clears the guard
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r        <= '0;
      s_r.div_hi <= DIV_HI_RESET;
      s_r.tamp_hist <= 2'b11;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign prdata      = s_r.prdata;
  assign half_tick   = s_r.half;
  assign pw_clk_tick = s_r.pw_tick;
  // polarity applies whether or not the pin is driven
  assign power_out   = s_r.ctrl_a[PWPOL_BIT] ~^ s_r.pw_tick;
  assign power_oe_n  = ~s_r.ctrl_a[PWOE_BIT];
  assign tick_out    = s_r.tick_out & s_r.ctrl_a[TOE_BIT];
  assign tick_oe_n   = ~s_r.ctrl_a[TOE_BIT];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_guard_blocks_div: assert property (@(posedge pclk) disable iff (!presetn)
    (guard && wr && paddr == ADDR_DIV_HI) |=> $stable(s_r.div_hi))
    else $error("divider changed while guarded");
  a_alarm_free_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == ADDR_ALARM && !alarm_match)
      |=> s_r.alarm == $past(pwdata[15:0] & ALARM_MASK))
    else $error("alarm write lost");
  a_guard_needs_key: assert property (@(posedge pclk) disable iff (!presetn)
    (guard && s_r.key != KEY_OPEN) |=> guard)
    else $error("guard cleared without key");
  a_guard_set_free: assert property (@(posedge pclk) disable iff (!presetn)
    (!guard && wr && paddr == ADDR_CTRL_A && pwdata[GUARD_BIT]) |=> guard)
    else $error("guard not set");
  a_stopped_no_tick: assert property (@(posedge pclk) disable iff (!presetn)
    !run |=> !half_tick)
    else $error("tick while stopped");
  a_repeat_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (arm_evt && s_r.alarm[7:0] == 8'h00 && !s_r.alarm[ENDL_BIT])
      |=> !s_r.alarm[ARM_BIT] && s_r.alarm[7:0] == 8'h00)
    else $error("alarm not disarmed");
  a_repeat_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (arm_evt && s_r.alarm[7:0] == 8'h00 && s_r.alarm[ENDL_BIT]
      && !(wr && paddr == ADDR_ALARM)) |=> s_r.alarm[7:0] == 8'hff)
    else $error("repeat did not wrap");
  a_stamp_off: assert property (@(posedge pclk) disable iff (!presetn)
    !s_r.ctrl_a[0] |=> !s_r.stamp_evt)
    else $error("stamp while disabled");
  a_reset_guard: assert property (@(posedge pclk)
    $rose(presetn) |-> !guard)
    else $error("guard set after reset");

endmodule

// ===== tb/test_cal_ctl.sv
// testbench: apb access, write guard, divider periods, alarm repeat
`timescale 1ns/100ps

module test_cal_ctl
  import cal_ctl_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        alarm_match, tamper_n_pin, err, seen;
  logic [2:0]  src, src_on;
  logic        half_tick, pw_clk_tick, power_out, power_oe_n;
  logic        tick_out, tick_oe_n;
  int          bad_count, checks_done, n, sum;
  int          pre[4] = '{1, 16, 64, 256};
  logic [11:0] ka[4][3];
  logic [31:0] kd[4][3];

  cal_ctl dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .secondary_osc(src[0]),
    .low_power_rc(src[1]), .mains_clk_pin(src[2]),
    .tamper_n_pin(tamper_n_pin), .alarm_match(alarm_match),
    .half_tick(half_tick), .pw_clk_tick(pw_clk_tick),
    .power_out(power_out), .power_oe_n(power_oe_n),
    .tick_out(tick_out), .tick_oe_n(tick_oe_n)
  );

  // ----------------------------------------------------------------
  // clocks: pclk 50 MHz, reference sources 8 pclk periods when on
  // ----------------------------------------------------------------
  always #10 pclk = ~pclk;
  always #80 src = src ^ src_on;

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, got, exp);
    end
  endtask

  // one apb transfer; holds the request until pready is seen high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 64);
    if (w >= 64) begin
      bad_count++;
      $display("unexpected at %0t: no pready", $time);
      close_out;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // cycles up to the next half tick; 3000 means none came
  task gap(output int c);
    c = 1;
    @(posedge pclk);
    while (half_tick !== 1'b1 && c < 3000) begin
      @(posedge pclk);
      c++;
    end
  endtask

  task fire;
    alarm_match <= 1'b1;
    @(posedge pclk);
    alarm_match <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task fin(input string s);
    $display("test %s done", s);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; alarm_match = 0; tamper_n_pin = 1;
    src = 0; src_on = 0;
    ka = '{'{ADDR_KEY, ADDR_ALARM, ADDR_KEY}, '{ADDR_ALARM, ADDR_KEY,
           ADDR_KEY}, '{ADDR_KEY, ADDR_KEY, ADDR_ALARM},
           '{ADDR_ALARM, ADDR_KEY, ADDR_KEY}};
    kd = '{'{32'h55, 32'h5, 32'haa}, '{32'h5, 32'haa, 32'h55},
           '{32'h55, 32'haa, 32'h5}, '{32'h5, 32'h55, 32'haa}};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(ADDR_CTRL_A, 32'h0);
    rdchk(ADDR_ALARM, 32'h0);
    rdchk(ADDR_DIV_LO, 32'h0);
    rdchk(ADDR_DIV_HI, {16'h0, DIV_HI_RESET});
    chk({power_out, power_oe_n, tick_oe_n}, 32'h7);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(err, 32'(i == 7));
    end
    wr(ADDR_ALARM, 32'hffff_ffff);
    rdchk(ADDR_ALARM, {16'h0, ALARM_MASK});
    wr(ADDR_DIV_LO, 32'hffff_ffff);
    rdchk(ADDR_DIV_LO, {16'h0, DIV_LO_MASK});
    for (int i = 0; i < 10; i++) begin
      wr(ADDR_ALARM, 32'(i) << 8);
      rdchk(ADDR_ALARM, 32'(i) << 8);
    end
    fin("registers");
    // pclk reference, coarse 3: period is prescale times four
    wr(ADDR_DIV_HI, 32'h3);
    wr(ADDR_CTRL_A, 32'h8000);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_DIV_LO, (32'(i) << 4) | 32'h3);
      gap(n);
      gap(n);
      chk(n, pre[i] * 4);
    end
    foreach (pre[t]) begin
      sum = 0;
      wr(ADDR_DIV_LO, (32'(t * 10 + 1) << 11) | 32'h3);
      gap(n);
      repeat (FRAC_SLOTS) begin
        gap(n);
        sum += n;
      end
      chk(sum, 128 + t * 10 + 1);
    end
    for (int k = 0; k < 3; k++) begin
      src_on <= 3'(1 << k);
      wr(ADDR_DIV_LO, 32'(k));
      gap(n);
      gap(n);
      chk(n, 32);
    end
    src_on <= 3'b110;
    wr(ADDR_DIV_LO, 32'h0);
    repeat (4) @(posedge pclk);
    gap(n);
    chk(n, 3000);
    src_on <= 3'b000;
    wr(ADDR_DIV_LO, 32'h3);
    wr(ADDR_CTRL_A, 32'h0);
    repeat (4) @(posedge pclk);
    gap(n);
    chk(n, 3000);
    fin("divider");
    // guard set with run on; locked fields hold, others move
    wr(ADDR_CTRL_A, 32'h8800);
    rdchk(ADDR_CTRL_A, 32'h8800);
    wr(ADDR_CTRL_A, 32'h0f80);
    rdchk(ADDR_CTRL_A, 32'h8f80);
    chk({power_oe_n, tick_oe_n}, 32'h0);
    wr(ADDR_DIV_HI, 32'h7);
    rdchk(ADDR_DIV_HI, 32'h3);
    gap(n);
    gap(n);
    chk(n, 4);
    // power prescale stays writable under guard; 1:16 gives 4 in 64
    wr(ADDR_DIV_LO, 32'h43);
    sum = 0;
    repeat (64) begin
      @(posedge pclk);
      sum += pw_clk_tick + power_out;
    end
    chk(sum, 8);
    wr(ADDR_ALARM, 32'h6);
    rdchk(ADDR_ALARM, 32'h6);
    // only the last row writes the keys back to back right before the clear
    for (int r = 0; r < 4; r++) begin
      for (int j = 0; j < 3; j++)
        wr(ka[r][j], kd[r][j]);
      wr(ADDR_CTRL_A, 32'h8780);
      rdchk(ADDR_CTRL_A, (r == 3) ? 32'h8780 : 32'h8f80);
    end
    fin("guard");
    wr(ADDR_ALARM, 32'h8001);
    fire;
    rdchk(ADDR_ALARM, 32'h8000);
    fire;
    rdchk(ADDR_ALARM, 32'h0);
    wr(ADDR_ALARM, 32'hc000);
    fire;
    rdchk(ADDR_ALARM, 32'hc0ff);
    fire;
    rdchk(ADDR_ALARM, 32'hc0fe);
    fin("alarm");
    // timestamp event routed to the output pin, stamping off then on
    for (int j = 0; j < 2; j++) begin
      wr(ADDR_CTRL_A, 32'h00c0 | 32'(j));
      tamper_n_pin <= 1'b0;
      repeat (3) @(posedge pclk);
      tamper_n_pin <= 1'b1;
      seen = 1'b0;
      repeat (10) begin
        @(posedge pclk);
        seen = seen | tick_out;
      end
      chk(seen, 32'(j));
    end
    fin("tamper");
    wr(ADDR_CTRL_A, 32'h0800);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(ADDR_CTRL_A, 32'h0);
    rdchk(ADDR_DIV_HI, {16'h0, DIV_HI_RESET});
    fin("second reset");
    close_out;
  end
endmodule
